// file: rtl/eesw_fifo.sv
// Synchronous FIFO holding received page bytes until the write cycle
`timescale 1ns/10ps
`default_nettype none
module eesw_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  eesw_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic full;
  logic empty;

  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW] != rptr_reg[AW]) &&
                (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign f.wr_ready = !full;
  assign f.rd_valid = !empty;
  assign f.rd_data = store[rptr_reg[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (clk_en && f.wr_valid && !full && !f.flush) begin
      store[wptr_reg[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (clk_en) begin
      if (f.flush) begin
        wptr_reg <= '0;
        rptr_reg <= '0;
      end else begin
        if (f.wr_valid && !full) begin
          wptr_reg <= wptr_reg + 1'b1;
        end
        if (f.rd_ready && !empty) begin
          rptr_reg <= rptr_reg + 1'b1;
        end
      end
    end
  end
endmodule // eesw_fifo
`default_nettype wire

// file: rtl/eesw_fifo_if.sv
// Stream carrier between the byte receiver and the page FIFO
`timescale 1ns/10ps
`default_nettype none
interface eesw_fifo_if #(
  parameter int WIDTH = 12
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic flush;
  modport producer (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data
  );
  modport fifo (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data
  );
endinterface
`default_nettype wire

// file: rtl/eesw_pkg.sv
// Shared constants and types for the serial memory slave write path
package eesw_pkg;
  // Fixed upper nibble of the slave address
  localparam logic [3:0] DEV_ID = 4'hA;
  // Address bits checked against the straps; the rest pick the page bank
  localparam logic [2:0] STRAP_MASK_DEF = 3'h4;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PER_US = CLK_HZ / 1000000;
  // Power-up ready delay, 0.35 ms
  localparam int POWERUP_READY_DELAY_US = 350;
  // Internal write cycle, 4 ms
  localparam int WRITE_CYCLE_US = 4000;
  localparam int PU_CYCLES = POWERUP_READY_DELAY_US * CLK_PER_US;
  localparam int WR_CYCLES = WRITE_CYCLE_US * CLK_PER_US;
  localparam int TIMER_W = 17;
  localparam int MEM_ADDR_W = 10;
  localparam int PTR_W = 11;
  localparam int PAGE_BITS = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = PAGE_BITS + 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_WORD = 4'h3,
    ST_WORD_ACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_READ = 4'h7,
    ST_READ_ACK = 4'h8,
    ST_SKIP = 4'h9
  } eesw_state_t;
endpackage

// file: rtl/eesw_slave.sv
// Two-wire serial memory slave: addressing, page write, write cycle
`timescale 1ns/10ps
`default_nettype none
module eesw_slave #(
  parameter int PU_CYCLES = eesw_pkg::PU_CYCLES,
  parameter int WR_CYCLES = eesw_pkg::WR_CYCLES,
  parameter logic [2:0] STRAP_MASK = eesw_pkg::STRAP_MASK_DEF,
  parameter int FIFO_DEPTH = eesw_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  input wire logic wp_in,
  output logic write_busy
);
  eesw_fifo_if #(.WIDTH(eesw_pkg::FIFO_W)) fq ();

  eesw_fifo #(
    .WIDTH(eesw_pkg::FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .f(fq.fifo)
  );

  logic [7:0] mem [2**eesw_pkg::MEM_ADDR_W];
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_reg;
  logic [1:0] wp_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  eesw_pkg::eesw_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [eesw_pkg::PTR_W-1:0] ptr_reg;
  logic [eesw_pkg::PTR_W-1:0] page_reg;
  logic wp_lat_reg;
  logic master_ack_reg;
  logic pending_reg;
  logic push_reg;
  logic flush_reg;
  logic busy_reg;
  logic ready_reg;
  logic sda_oe_reg;
  logic [eesw_pkg::TIMER_W-1:0] pu_cnt_reg;
  logic [eesw_pkg::TIMER_W-1:0] wr_cnt_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic dev_ok;
  logic data_ok;

  // Fixed nibble plus strapped middle bits must agree
  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [2:0] strap,
                                      input logic [2:0] mask);
    addr_match = (a[7:4] == eesw_pkg::DEV_ID) &&
                 (((a[3:1] ^ strap) & mask) == 3'h0);
  endfunction

  // Pins are asynchronous to clk_sys; only second stages are read
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      strap_s1_reg <= 3'h0;
      strap_reg <= 3'h0;
      wp_sync_reg <= 2'h0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      strap_s1_reg <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_reg <= strap_s1_reg;
      wp_sync_reg <= {wp_sync_reg[0], wp_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_rise = clk_en && scl_sync_reg[1] && !scl_prev_reg;
  assign scl_fall = clk_en && !scl_sync_reg[1] && scl_prev_reg;
  // Data edges with clock high both before and now
  assign start_det = clk_en && scl_sync_reg[1] && scl_prev_reg &&
                     sda_prev_reg && !sda_sync_reg[1];
  assign stop_det = clk_en && scl_sync_reg[1] && scl_prev_reg &&
                    !sda_prev_reg && sda_sync_reg[1];
  assign byte_end = scl_fall && (bitcnt_reg == eesw_pkg::BYTE_BITS);
  // Busy or not yet ready means no answer at all
  assign dev_ok = ready_reg && !busy_reg &&
                  addr_match(shift_reg, strap_reg, STRAP_MASK);
  // Protect latch or a full queue refuses the byte
  assign data_ok = !wp_lat_reg && fq.wr_ready;

  assign fq.wr_valid = push_reg;
  assign fq.wr_data = {ptr_reg[eesw_pkg::PAGE_BITS-1:0], shift_reg};
  assign fq.flush = flush_reg;
  assign fq.rd_ready = busy_reg;

  // Power-up delay after the detector releases
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pu_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (clk_en && !ready_reg) begin
      if (pu_cnt_reg == eesw_pkg::TIMER_W'(PU_CYCLES - 1)) begin
        ready_reg <= 1'b1;
      end
      pu_cnt_reg <= pu_cnt_reg + 1'b1;
    end
  end

  // Protocol engine
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= eesw_pkg::ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      ptr_reg <= '0;
      wp_lat_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      push_reg <= 1'b0;
    end else if (clk_en) begin
      push_reg <= 1'b0;
      if (start_det) begin
        state_reg <= eesw_pkg::ST_DEV;
        bitcnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= eesw_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        if (scl_rise && bitcnt_reg != eesw_pkg::BYTE_BITS) begin
          shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end
        case (state_reg)
          eesw_pkg::ST_DEV: begin
            // Count holds at eight so the ack slot never shifts in
            if (byte_end) begin
              if (dev_ok) begin
                state_reg <= eesw_pkg::ST_DEV_ACK;
                sda_oe_reg <= 1'b1;
                // Unstrapped middle bits pick the upper pointer bits
                ptr_reg[10:8] <= (ptr_reg[10:8] & STRAP_MASK) |
                                 (shift_reg[3:1] & ~STRAP_MASK);
              end else begin
                state_reg <= eesw_pkg::ST_SKIP;
              end
            end
          end
          eesw_pkg::ST_DEV_ACK: begin
            if (scl_fall) begin
              bitcnt_reg <= 4'h0;
              if (shift_reg[0]) begin
                state_reg <= eesw_pkg::ST_READ;
                tx_reg <= mem[ptr_reg[eesw_pkg::MEM_ADDR_W-1:0]];
                sda_oe_reg <= !mem[ptr_reg[eesw_pkg::MEM_ADDR_W-1:0]][7];
              end else begin
                state_reg <= eesw_pkg::ST_WORD;
                sda_oe_reg <= 1'b0;
              end
            end
          end
          eesw_pkg::ST_WORD: begin
            if (byte_end) begin
              ptr_reg[7:0] <= shift_reg;
              state_reg <= eesw_pkg::ST_WORD_ACK;
              sda_oe_reg <= 1'b1;
            end
          end
          eesw_pkg::ST_WORD_ACK: begin
            if (scl_fall) begin
              wp_lat_reg <= wp_sync_reg[1];
              bitcnt_reg <= 4'h0;
              state_reg <= eesw_pkg::ST_DATA;
              sda_oe_reg <= 1'b0;
            end
          end
          eesw_pkg::ST_DATA: begin
            if (byte_end) begin
              if (data_ok) begin
                push_reg <= 1'b1;
                state_reg <= eesw_pkg::ST_DATA_ACK;
                sda_oe_reg <= 1'b1;
              end else begin
                state_reg <= eesw_pkg::ST_SKIP;
              end
            end
          end
          eesw_pkg::ST_DATA_ACK: begin
            if (push_reg) begin
              // Low nibble only, so the page wraps
              ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
            end
            if (scl_fall) begin
              bitcnt_reg <= 4'h0;
              state_reg <= eesw_pkg::ST_DATA;
              sda_oe_reg <= 1'b0;
            end
          end
          eesw_pkg::ST_READ: begin
            if (byte_end) begin
              sda_oe_reg <= 1'b0;
              state_reg <= eesw_pkg::ST_READ_ACK;
              ptr_reg <= ptr_reg + 1'b1;
            end else if (scl_fall) begin
              tx_reg <= {tx_reg[6:0], 1'b1};
              sda_oe_reg <= !tx_reg[6];
            end
          end
          eesw_pkg::ST_READ_ACK: begin
            if (scl_rise) begin
              master_ack_reg <= !sda_sync_reg[1];
            end
            if (scl_fall) begin
              bitcnt_reg <= 4'h0;
              if (master_ack_reg) begin
                state_reg <= eesw_pkg::ST_READ;
                tx_reg <= mem[ptr_reg[eesw_pkg::MEM_ADDR_W-1:0]];
                sda_oe_reg <= !mem[ptr_reg[eesw_pkg::MEM_ADDR_W-1:0]][7];
              end else begin
                state_reg <= eesw_pkg::ST_SKIP;
              end
            end
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Commit bookkeeping: only a stop after accepted data starts a cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
      flush_reg <= 1'b0;
      page_reg <= '0;
    end else if (clk_en) begin
      flush_reg <= 1'b0;
      if (stop_det) begin
        pending_reg <= 1'b0;
        page_reg <= ptr_reg;
      end else if (start_det && pending_reg) begin
        // Abandoned command must not leak into a later commit
        pending_reg <= 1'b0;
        flush_reg <= 1'b1;
      end else if (state_reg == eesw_pkg::ST_DATA && byte_end) begin
        if (data_ok) begin
          pending_reg <= 1'b1;
        end else begin
          pending_reg <= 1'b0;
          flush_reg <= 1'b1;
        end
      end
    end
  end

  // Write cycle timer; queue drains only while busy
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      wr_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!busy_reg) begin
        if (stop_det && pending_reg) begin
          busy_reg <= 1'b1;
          wr_cnt_reg <= '0;
        end
      end else if (wr_cnt_reg == eesw_pkg::TIMER_W'(WR_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end else begin
        wr_cnt_reg <= wr_cnt_reg + 1'b1;
      end
    end
  end

  // Later entries for the same offset overwrite earlier ones
  always_ff @(posedge clk_sys) begin
    if (clk_en && busy_reg && fq.rd_valid) begin
      mem[{page_reg[eesw_pkg::MEM_ADDR_W-1:eesw_pkg::PAGE_BITS],
           fq.rd_data[eesw_pkg::FIFO_W-1:8]}] <= fq.rd_data[7:0];
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      write_busy <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      sda_oe <= sda_oe_reg;
      write_busy <= busy_reg;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_drive_after_fall;
    $rose(sda_oe_reg) |-> $past(scl_fall);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("sda drive began without a clock fall");

  property p_busy_released;
    busy_reg |-> !sda_oe_reg;
  endproperty
  a_busy_released: assert property (p_busy_released)
    else $error("sda driven during write cycle");

  property p_start_dev;
    start_det |=> state_reg == eesw_pkg::ST_DEV && !sda_oe_reg;
  endproperty
  a_start_dev: assert property (p_start_dev)
    else $error("start did not open address phase");

  property p_stop_idle;
    stop_det |=> state_reg == eesw_pkg::ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not end command");

  property p_bad_id_skip;
    state_reg == eesw_pkg::ST_DEV && byte_end && !start_det && !stop_det &&
    shift_reg[7:4] != eesw_pkg::DEV_ID |=>
      state_reg == eesw_pkg::ST_SKIP && !sda_oe_reg;
  endproperty
  a_bad_id_skip: assert property (p_bad_id_skip)
    else $error("foreign address not ignored");

  property p_busy_nack;
    state_reg == eesw_pkg::ST_DEV && byte_end && busy_reg &&
    !start_det && !stop_det |=> state_reg == eesw_pkg::ST_SKIP;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("address acknowledged while busy");

  property p_not_ready_quiet;
    !ready_reg |-> !sda_oe_reg;
  endproperty
  a_not_ready_quiet: assert property (p_not_ready_quiet)
    else $error("driven before power-up delay ended");

  property p_commit_on_stop;
    stop_det && pending_reg && !busy_reg |=> busy_reg ##1 busy_reg;
  endproperty
  a_commit_on_stop: assert property (p_commit_on_stop)
    else $error("stop after data did not start write cycle");

  property p_wp_reject;
    state_reg == eesw_pkg::ST_DATA && byte_end && wp_lat_reg &&
    !start_det && !stop_det |=> state_reg == eesw_pkg::ST_SKIP && !push_reg;
  endproperty
  a_wp_reject: assert property (p_wp_reject)
    else $error("protected write byte accepted");

  property p_page_wrap;
    push_reg && clk_en |=> ptr_reg[10:4] == $past(ptr_reg[10:4]) &&
      ptr_reg[3:0] == 4'($past(ptr_reg[3:0]) + 4'h1);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("pointer stepped outside low nibble");

  c_read_byte: cover property (state_reg == eesw_pkg::ST_READ_ACK);
  c_commit: cover property (stop_det && pending_reg ##1 busy_reg);
  c_poll_nack: cover property (busy_reg && byte_end &&
                               state_reg == eesw_pkg::ST_DEV);
endmodule // eesw_slave
`default_nettype wire

// file: verif/eeprom_i2c_slave_write_path_bench.sv
// Self-checking bench for the serial memory slave write path
`timescale 1ns/10ps
`default_nettype none
module eeprom_i2c_slave_write_path_bench;
  // Shortened delays keep the run brief
  localparam int PU = 150;
  localparam int WR = 200;
  logic clk_sys;
  logic reset_n;
  logic wp_in;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  wire logic sda_wire;
  int n_errors;
  int samples_checked;
  int busy_cnt;
  assign sda_wire = !(sda_oe | sda_low);
  eesw_master m_u (
    .clk_sys(clk_sys),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_low(sda_low)
  );
  eesw_slave #(.PU_CYCLES(PU), .WR_CYCLES(WR)) dut_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(1'b1),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .strap_addr_bit0(1'b0),
    .strap_addr_bit1(1'b0),
    .strap_addr_bit2(1'b1),
    .wp_in(wp_in),
    .write_busy(write_busy)
  );
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (write_busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] sa(input logic [1:0] bank, input logic rw);
    return {eesw_pkg::DEV_ID, 1'b1, bank, rw};
  endfunction
  task automatic send(input logic [7:0] d, output logic r);
    logic [7:0] q;
    m_u.xfer(d, 1'b1, q, r);
  endtask
  // Bounded wait for the busy flag; a timeout ends the run
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (write_busy !== lvl && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    check("busy_wait", {7'h00, write_busy}, {7'h00, lvl});
    if (write_busy !== lvl) begin
      close_out();
    end
  endtask
  task automatic t_early();
    logic r;
    m_u.start();
    send(sa(2'h0, 1'b0), r);
    check("early_ack", {7'h00, r}, 8'h01);
    m_u.stop();
  endtask
  task automatic t_refuse();
    logic r;
    send(sa(2'h0, 1'b0), r);
    check("no_start", {7'h00, r}, 8'h01);
    m_u.start();
    send(8'h52, r);
    check("nibble", {7'h00, r}, 8'h01);
    send(8'h00, r);
    check("ignored", {7'h00, r}, 8'h01);
    m_u.start();
    send({eesw_pkg::DEV_ID, 4'h0}, r);
    check("strap", {7'h00, r}, 8'h01);
    m_u.stop();
  endtask
  task automatic t_write(input logic [1:0] bank, input logic [7:0] word,
      input logic [7:0] first, input int n);
    logic r;
    m_u.start();
    send(sa(bank, 1'b0), r);
    check("addr_ack", {7'h00, r}, 8'h00);
    send(word, r);
    check("word_ack", {7'h00, r}, 8'h00);
    for (int i = 0; i < n; i++) begin
      send(first + 8'(i), r);
      check("data_ack", {7'h00, r}, 8'h00);
    end
    check("busy_early", {7'h00, write_busy}, 8'h00);
    busy_cnt = 0;
    m_u.stop();
    wait_busy(1'b1, 20);
    m_u.start();
    send(sa(bank, 1'b0), r);
    check("poll_busy", {7'h00, r}, 8'h01);
    m_u.stop();
    wait_busy(1'b0, WR + 50);
    check("busy_len", 8'(busy_cnt), 8'(WR));
    m_u.start();
    send(sa(bank, 1'b0), r);
    check("poll_done", {7'h00, r}, 8'h00);
    m_u.stop();
  endtask
  task automatic t_read(input logic [1:0] bank, input logic [7:0] word,
      input logic [7:0] first, input int n);
    logic r;
    logic [7:0] q;
    m_u.start();
    send(sa(bank, 1'b0), r);
    send(word, r);
    m_u.start();
    send(sa(bank, 1'b1), r);
    check("rd_addr_ack", {7'h00, r}, 8'h00);
    for (int i = 0; i < n; i++) begin
      m_u.xfer(8'hFF, i == n - 1, q, r);
      check("rd_data", q, first + 8'(i));
    end
    check("rd_release", {7'h00, r}, 8'h01);
    check("sda_out", {7'h00, sda_out}, 8'h00);
    m_u.stop();
  endtask
  task automatic t_protect();
    logic r;
    wp_in = 1'b1;
    m_u.start();
    send(sa(2'h2, 1'b0), r);
    send(8'h05, r);
    check("wp_word_ack", {7'h00, r}, 8'h00);
    send(8'h00, r);
    check("wp_data_ack", {7'h00, r}, 8'h01);
    m_u.stop();
    m_u.tick(20);
    check("wp_busy", {7'h00, write_busy}, 8'h00);
    wp_in = 1'b0;
    t_read(2'h2, 8'h05, 8'h5A, 1);
  endtask
  initial begin
    reset_n = 1'b0;
    wp_in = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    busy_cnt = 0;
    repeat (5) @(negedge clk_sys);
    check("rst_oe", {7'h00, sda_oe}, 8'h00);
    check("rst_busy", {7'h00, write_busy}, 8'h00);
    reset_n = 1'b1;
    t_early();
    repeat (PU) @(negedge clk_sys);
    t_refuse();
    t_write(2'h2, 8'h05, 8'h5A, 1);
    t_read(2'h2, 8'h05, 8'h5A, 1);
    // Eighteen bytes from offset E wrap, so page 30 reads A2 upwards
    t_write(2'h1, 8'h3E, 8'hA0, 18);
    t_read(2'h1, 8'h30, 8'hA2, 16);
    t_protect();
    close_out();
  end
endmodule // eeprom_i2c_slave_write_path_bench
`default_nettype wire

// file: verif/eesw_master.sv
// Bus master model that drives the serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module eesw_master (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // Released pins idle high through the pull-ups
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Also a repeated start when entered with the clock low
  task automatic start();
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  // Leaves the bus idle with both lines released
  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // Data moves mid-low only, so it is stable while the clock is high
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(3);
    r = sda_wire;
    tick(1);
    scl = 1'b0;
  endtask
  // Eight bits MSB first, then the ninth slot; nine = 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic nine,
      output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(nine, r9);
  endtask
endmodule // eesw_master
`default_nettype wire
